// ===== sleep_wake_control.sv
// sleep entry, wake decision and refresh gating for the processor core
// assumes core, peripherals and refresh timer run on CLK_SYS_I; pins are asynchronous
`timescale 1ns/1ps

// Notes on behaviour
// - reset held low six clocks while asleep ends sleep and restarts from address zero.
// - sleep also ends on an nmi, ext_irq_0, ext_irq_2, serial channel, clocked serial or timer interrupt.
// - an nmi during sleep wakes the core into the nmi response, whatever the enables, unless a reset exit falls in the same cycle.
// - a maskable source whose own enable is clear is ignored and the core stays asleep.
// - an enabled maskable source with global_irq_enable_flag set wakes into its interrupt response.
// - an enabled maskable source with global_irq_enable_flag clear wakes and resumes after sleep_instruction.
// - no refresh is inserted while asleep, in reset, with the bus released or during wait states.
module sleep_wake_control
  import sleep_wake_pkg::*;
(
  input  wire logic                    CLK_SYS_I,
  input  wire logic                    RST_I,
  input  wire logic                    RESET_N_PIN_I,
  input  wire logic                    NMI_N_PIN_I,
  input  wire logic                    EXT_IRQ_0_N_I,
  input  wire logic                    EXT_IRQ_2_N_I,
  input  wire logic                    ASYNC_SERIAL_IRQ_I,
  input  wire logic                    CLOCKED_SERIAL_IRQ_I,
  input  wire logic                    RELOAD_TIMER_IRQ_I,
  input  wire logic [NUM_MASKABLE-1:0] SRC_ENABLE_I,
  input  wire logic                    GLOBAL_IRQ_ENABLE_FLAG_I,
  input  wire logic                    SLEEP_INSTRUCTION_I,
  input  wire logic                    BUS_RELEASED_I,
  input  wire logic                    WAIT_STATE_I,
  input  wire logic                    REFRESH_DUE_I,
  input  wire logic                    WAKE_ACK_I,
  output logic                         SLEEPING_O,
  output logic                         FETCH_HALT_O,
  output logic                         REFRESH_ALLOW_O,
  output logic                         CORE_RESET_O,
  output logic [19:0]                  RESTART_ADDR_O,
  output logic                         WAKE_VALID_O,
  output logic [1:0]                   WAKE_KIND_O,
  output logic [NUM_MASKABLE-1:0]      WAKE_SRC_O
);
  wake_if wk ();

  wake_sync u_sync (
    .clk_i           (CLK_SYS_I),
    .rst_i           (RST_I),
    .reset_n_pin_i   (RESET_N_PIN_I),
    .nmi_n_pin_i     (NMI_N_PIN_I),
    .ext_irq_n_pin_i ({EXT_IRQ_2_N_I, EXT_IRQ_0_N_I}),
    .int_irq_i       ({RELOAD_TIMER_IRQ_I, CLOCKED_SERIAL_IRQ_I, ASYNC_SERIAL_IRQ_I}),
    .wk              (wk)
  );

  wake_state_t                 state_q,  state_d;
  logic [2:0]                  rcnt_q,   rcnt_d;
  logic                        nmi_q,    nmi_d;
  logic                        sleep_q,  sleep_d;
  logic                        halt_q,   halt_d;
  logic                        refr_q,   refr_d;
  logic                        crst_q,   crst_d;
  logic [19:0]                 addr_q,   addr_d;
  logic                        wval_q,   wval_d;
  logic [1:0]                  wkind_q,  wkind_d;
  logic [NUM_MASKABLE-1:0]     wsrc_q,   wsrc_d;
  logic [NUM_MASKABLE-1:0]     enabled_hits;
  logic                        nmi_edge;
  logic                        in_sleep;
  logic                        reset_exit;
  logic                        nmi_wake;
  logic                        irq_wake;
  logic                        ack_take;
  logic                        pin_release;

  // wake decisions shared by the groups below: reset exit outranks nmi, nmi outranks the rest
  always_comb begin
    enabled_hits = wk.irq & SRC_ENABLE_I;
    nmi_edge     = wk.nmi & ~nmi_q;
    in_sleep     = (state_q == ST_SLEEP);
    reset_exit   = in_sleep && (rcnt_q == RESET_CNT_MAX);
    nmi_wake     = in_sleep && !reset_exit && nmi_edge;
    irq_wake     = in_sleep && !reset_exit && !nmi_edge && (|enabled_hits);
    ack_take     = (state_q == ST_WAKE) && WAKE_ACK_I;
    pin_release  = (state_q == ST_RESET) && !wk.reset_low;
  end

  // low-reset counter saturates so a long hold stays a single event
  always_comb begin
    rcnt_d = 3'h0;
    if (wk.reset_low) begin
      rcnt_d = rcnt_q;
      if (rcnt_q != RESET_CNT_MAX) begin
        rcnt_d = rcnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rcnt_q <= 3'h0;
    end else begin
      rcnt_q <= rcnt_d;
    end
  end

  // edge memory: an nmi pin held low wakes only once
  always_comb begin
    nmi_d = wk.nmi;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= nmi_d;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (SLEEP_INSTRUCTION_I) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (reset_exit) begin
          state_d = ST_RESET;
        end else if (nmi_wake || irq_wake) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // result held until the core takes it
        if (ack_take) begin
          state_d = ST_RUN;
        end
      end
      ST_RESET: begin
        // core held in reset until the pin rises
        if (pin_release) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    wval_d  = wval_q;
    wkind_d = wkind_q;
    wsrc_d  = wsrc_q;
    addr_d  = addr_q;
    if (reset_exit) begin
      addr_d  = RESET_VECTOR;
    end else if (nmi_wake) begin
      wval_d  = 1'b1;
      wkind_d = WAKE_NMI;
      wsrc_d  = '0;
    end else if (irq_wake) begin
      wval_d  = 1'b1;
      wsrc_d  = enabled_hits;
      // flag clear: skip the response, fast resume for event sync
      wkind_d = GLOBAL_IRQ_ENABLE_FLAG_I ? WAKE_IRQ : WAKE_RESUME;
    end else if (ack_take) begin
      wval_d  = 1'b0;
      wkind_d = WAKE_NONE;
      wsrc_d  = '0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      addr_q  <= RESET_VECTOR;
      wval_q  <= 1'b0;
      wkind_q <= WAKE_NONE;
      wsrc_q  <= ENABLE_RESET;
    end else begin
      addr_q  <= addr_d;
      wval_q  <= wval_d;
      wkind_q <= wkind_d;
      wsrc_q  <= wsrc_d;
    end
  end

  // flags follow the next state so refresh is already withheld on the entry edge
  always_comb begin
    sleep_d = (state_d == ST_SLEEP);
    halt_d  = (state_d == ST_SLEEP) || (state_d == ST_RESET);
    crst_d  = (state_d == ST_RESET);
    refr_d  = REFRESH_DUE_I && (state_d == ST_RUN) && !BUS_RELEASED_I && !WAIT_STATE_I;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sleep_q <= 1'b0;
      halt_q  <= 1'b0;
      refr_q  <= 1'b0;
      crst_q  <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
      halt_q  <= halt_d;
      refr_q  <= refr_d;
      crst_q  <= crst_d;
    end
  end

  assign SLEEPING_O      = sleep_q;
  assign FETCH_HALT_O    = halt_q;
  assign REFRESH_ALLOW_O = refr_q;
  assign CORE_RESET_O    = crst_q;
  assign RESTART_ADDR_O  = addr_q;
  assign WAKE_VALID_O    = wval_q;
  assign WAKE_KIND_O     = wkind_q;
  assign WAKE_SRC_O      = wsrc_q;
endmodule // sleep_wake_control

// ===== sleep_wake_control_test.sv
// self-checking bench for the sleep/wake controller
// assumes 10 MHz clock, inputs changed 1 ns after the rising edge
`timescale 1ns/1ps
module sleep_wake_control_test;
  import sleep_wake_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, flag = 1'b0, sleep_req = 1'b0;
  logic        rel = 1'b0, wst = 1'b0, due = 1'b1, ack = 1'b0;
  logic [4:0]  en = 5'h00;
  logic        sleeping, halt, refr, core_rst, valid, rst_n, nmi_n;
  logic [19:0] addr;
  logic [1:0]  kind, ext_n;
  logic [4:0]  src;
  logic [2:0]  irq;
  int          n_errors = 0, n_tests = 0;
  always #50 clk = ~clk;
  sleep_wake_src_model src_m (.clk_i(clk), .reset_n_o(rst_n), .nmi_n_o(nmi_n), .ext_n_o(ext_n), .int_o(irq));
  sleep_wake_control dut (.CLK_SYS_I(clk), .RST_I(rst), .RESET_N_PIN_I(rst_n), .NMI_N_PIN_I(nmi_n),
    .EXT_IRQ_0_N_I(ext_n[0]), .EXT_IRQ_2_N_I(ext_n[1]), .ASYNC_SERIAL_IRQ_I(irq[0]),
    .CLOCKED_SERIAL_IRQ_I(irq[1]), .RELOAD_TIMER_IRQ_I(irq[2]), .SRC_ENABLE_I(en),
    .GLOBAL_IRQ_ENABLE_FLAG_I(flag), .SLEEP_INSTRUCTION_I(sleep_req), .BUS_RELEASED_I(rel), .WAIT_STATE_I(wst),
    .REFRESH_DUE_I(due), .WAKE_ACK_I(ack), .SLEEPING_O(sleeping), .FETCH_HALT_O(halt), .REFRESH_ALLOW_O(refr),
    .CORE_RESET_O(core_rst), .RESTART_ADDR_O(addr), .WAKE_VALID_O(valid), .WAKE_KIND_O(kind), .WAKE_SRC_O(src));
  task automatic report_and_stop;
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go_sleep;
    sleep_req = 1'b1;
    step(1);
    sleep_req = 1'b0;
    chk({sleeping, halt}, 2'h3);
    step(1);
    chk(refr, 1'b0);
  endtask
  task automatic wait_valid;
    for (int i = 0; i < 10 && valid !== 1'b1; i++) step(1);
    if (valid !== 1'b1) begin
      n_errors++;
      report_and_stop;
    end
  endtask
  task automatic do_ack;
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    chk(valid, 1'b0);
  endtask
  task automatic refresh;
    step(2);
    chk(refr, 1'b1);
    wst = 1'b1;
    step(2);
    chk(refr, 1'b0);
    wst = 1'b0;
    rel = 1'b1;
    step(2);
    chk(refr, 1'b0);
    rel = 1'b0;
  endtask
  task automatic masked;
    en = 5'h00;
    go_sleep;
    for (int i = 0; i < 5; i++) src_m.fire(i, 2);
    step(5);
    chk({valid, sleeping}, 2'h1);
  endtask
  task automatic nmi_wake;
    src_m.fire(5, 3);
    wait_valid;
    chk({kind, src}, 7'h20);
    do_ack;
  endtask
  // gap first: a released pin is still low inside the synchroniser
  task automatic wake_by(input int idx, input logic f);
    step(4);
    en = 5'h1f;
    flag = f;
    go_sleep;
    src_m.fire(idx, 4);
    wait_valid;
    chk(sleeping, 1'b0);
    chk(kind, f ? 2'h2 : 2'h3);
    chk(src, 5'h01 << idx);
    do_ack;
  endtask
  task automatic pin_reset;
    step(4);
    go_sleep;
    src_m.fire(6, 5);
    step(6);
    chk({core_rst, sleeping}, 2'h1);
    src_m.fire(6, 12);
    chk({core_rst, halt, refr}, 3'h6);
    chk(addr, RESET_VECTOR);
    step(6);
    chk({core_rst, halt, refr}, 3'h1);
  endtask
  // reset in mid sleep: outputs drop at once, refresh returns after release
  task automatic sleep_reset;
    go_sleep;
    rst = 1'b1;
    step(1);
    chk({sleeping, halt, refr}, 3'h0);
    step(4);
    rst = 1'b0;
    step(2);
    chk({sleeping, halt, refr}, 3'h1);
  endtask
  initial begin
    step(5);
    rst = 1'b0;
    chk({sleeping, halt, valid, core_rst}, 4'h0);
    refresh;
    sleep_reset;
    masked;
    nmi_wake;
    for (int i = 0; i < 5; i++) begin
      wake_by(i, 1'b1);
      wake_by(i, 1'b0);
    end
    pin_reset;
    report_and_stop;
  end
endmodule // sleep_wake_control_test
bind sleep_wake_control sleep_wake_monitor mon (.CLK_SYS_I, .RST_I, .RESET_N_PIN_I, .NMI_N_PIN_I,
  .ASYNC_SERIAL_IRQ_I, .CLOCKED_SERIAL_IRQ_I, .RELOAD_TIMER_IRQ_I, .SRC_ENABLE_I, .GLOBAL_IRQ_ENABLE_FLAG_I,
  .SLEEP_INSTRUCTION_I, .BUS_RELEASED_I, .WAIT_STATE_I, .REFRESH_DUE_I, .WAKE_ACK_I, .SLEEPING_O,
  .FETCH_HALT_O, .REFRESH_ALLOW_O, .CORE_RESET_O, .RESTART_ADDR_O, .WAKE_VALID_O, .WAKE_KIND_O, .WAKE_SRC_O);

// ===== sleep_wake_monitor.sv
// port assertions for the sleep/wake controller
// assumes bind from the bench top file, one clock domain
`timescale 1ns/1ps
module sleep_wake_monitor
  import sleep_wake_pkg::*;
(
  input wire logic                    CLK_SYS_I,
  input wire logic                    RST_I,
  input wire logic                    RESET_N_PIN_I,
  input wire logic                    NMI_N_PIN_I,
  input wire logic                    ASYNC_SERIAL_IRQ_I,
  input wire logic                    CLOCKED_SERIAL_IRQ_I,
  input wire logic                    RELOAD_TIMER_IRQ_I,
  input wire logic [NUM_MASKABLE-1:0] SRC_ENABLE_I,
  input wire logic                    GLOBAL_IRQ_ENABLE_FLAG_I,
  input wire logic                    SLEEP_INSTRUCTION_I,
  input wire logic                    BUS_RELEASED_I,
  input wire logic                    WAIT_STATE_I,
  input wire logic                    REFRESH_DUE_I,
  input wire logic                    WAKE_ACK_I,
  input wire logic                    SLEEPING_O,
  input wire logic                    FETCH_HALT_O,
  input wire logic                    REFRESH_ALLOW_O,
  input wire logic                    CORE_RESET_O,
  input wire logic [19:0]             RESTART_ADDR_O,
  input wire logic                    WAKE_VALID_O,
  input wire logic [1:0]              WAKE_KIND_O,
  input wire logic [NUM_MASKABLE-1:0] WAKE_SRC_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic [NUM_MASKABLE-1:0] hit;
  logic [3:0]              low_d;
  logic [3:0]              low_q;
  assign hit = {RELOAD_TIMER_IRQ_I, CLOCKED_SERIAL_IRQ_I, ASYNC_SERIAL_IRQ_I, 2'h0} & SRC_ENABLE_I;
  // saturates so a long reset hold cannot wrap back below six
  always_comb low_d = RESET_N_PIN_I ? 4'h0 : ((low_q == 4'hf) ? low_q : low_q + 4'h1);
  always_ff @(posedge CLK_SYS_I) low_q <= RST_I ? 4'h0 : low_d;
  sequence s_irq; SLEEPING_O && hit != 5'h00 && NMI_N_PIN_I && RESET_N_PIN_I; endsequence
  property p_entry; !SLEEPING_O && !CORE_RESET_O && !WAKE_VALID_O && SLEEP_INSTRUCTION_I
    |=> SLEEPING_O && FETCH_HALT_O; endproperty
  a_entry: assert property (p_entry) else $error("no sleep after sleep instruction");
  property p_halt; SLEEPING_O |-> FETCH_HALT_O; endproperty
  a_halt: assert property (p_halt) else $error("fetch runs while asleep");
  property p_kind; s_irq |=> WAKE_VALID_O && !SLEEPING_O
    && WAKE_KIND_O == ($past(GLOBAL_IRQ_ENABLE_FLAG_I) ? 2'h2 : 2'h3); endproperty
  a_kind: assert property (p_kind) else $error("wrong wake kind");
  property p_src; s_irq |=> WAKE_SRC_O == $past(hit); endproperty
  a_src: assert property (p_src) else $error("wrong wake source");
  property p_mask; (RESET_N_PIN_I && NMI_N_PIN_I)[*5] ##0 (SLEEPING_O && hit == 5'h00
    && SRC_ENABLE_I[1:0] == 2'h0) |=> SLEEPING_O; endproperty
  a_mask: assert property (p_mask) else $error("woke on disabled source");
  property p_nmi; $fell(NMI_N_PIN_I) && SLEEPING_O && RESET_N_PIN_I
    |-> ##[2:5] (WAKE_VALID_O && WAKE_KIND_O == 2'h1 && WAKE_SRC_O == 5'h00); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi did not wake");
  property p_rst; $rose(CORE_RESET_O) |-> low_q >= 4'h6 && RESTART_ADDR_O == RESET_VECTOR; endproperty
  a_rst: assert property (p_rst) else $error("bad reset exit");
  property p_refresh; REFRESH_ALLOW_O |-> !SLEEPING_O && !CORE_RESET_O && !WAKE_VALID_O
    && $past(REFRESH_DUE_I && !BUS_RELEASED_I && !WAIT_STATE_I); endproperty
  a_refresh: assert property (p_refresh) else $error("refresh not withheld");
  property p_hold; WAKE_VALID_O && !WAKE_ACK_I |=> WAKE_VALID_O && $stable(WAKE_SRC_O); endproperty
  a_hold: assert property (p_hold) else $error("wake result dropped");
  property p_ack; WAKE_VALID_O && WAKE_ACK_I |=> !WAKE_VALID_O; endproperty
  a_ack: assert property (p_ack) else $error("wake result not cleared");
  c_nmi: cover property (WAKE_VALID_O && WAKE_KIND_O == 2'h1);
  c_resume: cover property (WAKE_VALID_O && WAKE_KIND_O == 2'h3);
  c_reset: cover property ($rose(CORE_RESET_O));
endmodule // sleep_wake_monitor

// ===== sleep_wake_pkg.sv
// constants and types shared by the sleep/wake controller and its detector
// assumes a single 10 MHz system clock domain
package sleep_wake_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned RESET_EXIT_CYCLES = 6;
  localparam logic [2:0]  RESET_CNT_MAX     = 3'h6;
  localparam logic [19:0] RESET_VECTOR      = 20'h00000;
  localparam int unsigned NUM_MASKABLE      = 5;
  // bit positions of the maskable sources
  localparam int unsigned SRC_EXT_IRQ_0     = 0;
  localparam int unsigned SRC_EXT_IRQ_2     = 1;
  localparam int unsigned SRC_ASYNC_SERIAL  = 2;
  localparam int unsigned SRC_CLOCKED_SER   = 3;
  localparam int unsigned SRC_RELOAD_TIMER  = 4;
  localparam logic [4:0]  ENABLE_RESET      = 5'h00;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_SLEEP = 4'h2,
    ST_WAKE  = 4'h4,
    ST_RESET = 4'h8
  } wake_state_t;

  typedef enum logic [1:0] {
    WAKE_NONE = 2'h0,
    WAKE_NMI  = 2'h1,
    WAKE_IRQ  = 2'h2,
    WAKE_RESUME = 2'h3
  } wake_kind_t;
endpackage

// ===== sleep_wake_src_model.sv
// interrupt sources and reset driver in front of the controller
// assumes pins idle high (pulled up), internal requests idle low
`timescale 1ns/1ps
module sleep_wake_src_model (
  input  wire logic       clk_i,
  output logic            reset_n_o,
  output logic            nmi_n_o,
  output logic [1:0]      ext_n_o,
  output logic [2:0]      int_o
);
  // 0..1 ext pins, 2..4 internal, 5 nmi, 6 reset
  logic [6:0] act = 7'h00;
  assign ext_n_o   = ~act[1:0];
  assign int_o     = act[4:2];
  assign nmi_n_o   = ~act[5];
  assign reset_n_o = ~act[6];
  task automatic fire(input int idx, input int n);
    @(posedge clk_i);
    #1 act[idx] = 1'b1;
    repeat (n) @(posedge clk_i);
    #1 act[idx] = 1'b0;
  endtask
endmodule // sleep_wake_src_model

// ===== wake_if.sv
// carries the request levels, pins synchronised and internal sources direct, from the detector to the controller
// assumes both ends share CLK_SYS_I
`timescale 1ns/1ps
interface wake_if;
  import sleep_wake_pkg::*;
  logic                    reset_low;
  logic                    nmi;
  logic [NUM_MASKABLE-1:0] irq;
  modport src (output reset_low, output nmi, output irq);
  modport dst (input reset_low, input nmi, input irq);
endinterface

// ===== wake_sync.sv
// three-stage synchronisers for pin-level wake requests
// assumes pins are asynchronous to CLK_SYS_I; internal sources pass straight through
`timescale 1ns/1ps
module wake_sync
  import sleep_wake_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    reset_n_pin_i,
  input  wire logic                    nmi_n_pin_i,
  input  wire logic [1:0]              ext_irq_n_pin_i,
  input  wire logic [2:0]              int_irq_i,
  wake_if.src                          wk
);
  // bit 0 reset, 1 nmi, 2..3 external irqs
  logic [3:0] s1_q, s2_q, s3_q, st_q;
  logic [3:0] s1_d, s2_d, s3_d, st_d;

  always_comb begin
    s1_d = {~ext_irq_n_pin_i, ~nmi_n_pin_i, ~reset_n_pin_i};
    s2_d = s1_q;
    s3_d = s2_q;
    st_d = st_q;
    // only commit when the last two stages agree
    for (int i = 0; i < 4; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        st_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      st_q <= 4'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      st_q <= st_d;
    end
  end

  assign wk.reset_low = st_q[0];
  assign wk.nmi       = st_q[1];
  assign wk.irq       = {int_irq_i, st_q[3:2]};
endmodule // wake_sync
